// *** design/ext_wait_pkg.sv ***
// Shared constants and types for the external bus wait controller
package ext_wait_pkg;

	// ********************************************************
	// APB register map
	// ********************************************************
	localparam logic [7:0] WAIT_CTRL_OFS = 8'h00;
	localparam logic [7:0] AREA_CTRL_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS    = 8'h08;

	// ********************************************************
	// Wait state control fields and reset value
	// ********************************************************
	localparam int WIDE_WIDTH_BIT  = 7;
	localparam int WIDE_STATE_BIT  = 6;
	localparam int BASIC_WIDTH_BIT = 5;
	localparam int BASIC_STATE_BIT = 4;
	localparam int WMODE_HI        = 3;
	localparam int WMODE_LO        = 2;
	localparam int WCOUNT_HI       = 1;
	localparam int WCOUNT_LO       = 0;
	localparam logic [7:0] WAIT_CTRL_RST = 8'hf3;

	// Area control fields
	localparam int WIDE_EN_BIT = 0;
	localparam int CP_EN_BIT   = 1;
	localparam int MUX_EN_BIT  = 2;
	localparam logic [7:0] AREA_CTRL_RST = 8'h00;

	// ********************************************************
	// Fixed settings for areas whose own registers are not here
	// ********************************************************
	localparam logic       CP_WIDTH_8      = 1'b1;
	localparam logic       CP_THREE_STATE  = 1'b1;
	localparam logic [1:0] CP_WAIT_COUNT   = 2'h3;
	localparam logic [1:0] WIDE_WAIT_COUNT = 2'h3;

	// Access timing in clock cycles, one bus state per cycle
	localparam logic [1:0] ADDR_PHASE_CYCLES = 2'h2;

	// ********************************************************
	// Enumerations
	// ********************************************************
	typedef enum logic [1:0] {
		WM_PROGRAM  = 2'b00,
		WM_DISABLED = 2'b01,
		WM_PIN      = 2'b10,
		WM_PIN_AUTO = 2'b11
	} wait_mode_t;

	typedef enum logic [1:0] {
		RG_INT_MEM = 2'b00,
		RG_INT_IO  = 2'b01,
		RG_BASIC   = 2'b10,
		RG_WIDE    = 2'b11
	} region_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_DATA = 3'b010,
		S_WAIT = 3'b011,
		S_LAST = 3'b100
	} seq_state_t;

	localparam wait_mode_t CP_WAIT_MODE   = WM_PROGRAM;
	localparam wait_mode_t WIDE_WAIT_MODE = WM_PROGRAM;

endpackage

// *** design/pin_sync3.sv ***
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module pin_sync3
	import ext_wait_pkg::*;
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

	// A change counts only when stages two and three agree
	always_comb begin
		lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
	end

	// Stage one feeds stage two alone to bound metastability
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q  <= 1'b1;
			s2_q  <= 1'b1;
			s3_q  <= 1'b1;
			lvl_q <= 1'b1;
		end else if (ce) begin
			s1_q  <= pin_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign level_out = lvl_q;
endmodule

// *** design/apb_wait_regs.sv ***
// APB slave holding the wait and area control registers
`timescale 1ns/1ps
module apb_wait_regs
	import ext_wait_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [7:0]  status_in,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [7:0]       wait_ctrl,
	output logic [7:0]       area_ctrl
);
	logic [7:0]  wait_ctrl_q, wait_ctrl_d, area_ctrl_q, area_ctrl_d;
	logic [31:0] rdata_q, rdata_d;
	logic        mapped, access, setup;

	// Decode and next register values
	always_comb begin
		mapped = (paddr == WAIT_CTRL_OFS) || (paddr == AREA_CTRL_OFS) ||
			(paddr == STATUS_OFS);
		access = psel && penable;
		setup  = psel && !penable;
		wait_ctrl_d = wait_ctrl_q;
		area_ctrl_d = area_ctrl_q;
		rdata_d     = rdata_q;
		if (access && pwrite && paddr == WAIT_CTRL_OFS) begin
			wait_ctrl_d = pwdata[7:0];
		end
		if (access && pwrite && paddr == AREA_CTRL_OFS) begin
			area_ctrl_d = {5'h00, pwdata[2:0]};
		end
		// Read data captured in setup so it comes from flops
		if (setup) begin
			unique case (paddr)
				WAIT_CTRL_OFS: rdata_d = {24'h000000, wait_ctrl_q};
				AREA_CTRL_OFS: rdata_d = {24'h000000, area_ctrl_q};
				STATUS_OFS:    rdata_d = {24'h000000, status_in};
				default:       rdata_d = 32'h00000000;
			endcase
		end
	end

	// Registers load printed reset values
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_ctrl_q <= WAIT_CTRL_RST;
			area_ctrl_q <= AREA_CTRL_RST;
			rdata_q     <= 32'h00000000;
		end else if (ce) begin
			wait_ctrl_q <= wait_ctrl_d;
			area_ctrl_q <= area_ctrl_d;
			rdata_q     <= rdata_d;
		end
	end

	// Zero-wait slave; a frozen clock enable holds the access
	assign pready    = ce;
	assign pslverr   = access && !mapped;
	assign prdata    = rdata_q;
	assign wait_ctrl = wait_ctrl_q;
	assign area_ctrl = area_ctrl_q;
endmodule

// *** design/ext_bus_wait_ctrl.sv ***
// External area bus timing controller with APB configuration
//
// Contract
// - Internal memory and I/O accesses keep fixed width and timing.
// - With the wide area enabled its width bit picks 16 (0) or 8 (1) bits.
// - With the wide area enabled its state bit picks 2 states or 3 with waits.
// - With multiplexing on, state count and waits apply to the data phase.
// - The basic width bit picks a 16-bit (0) or 8-bit (1) basic area bus.
// - The basic state bit picks 2 states without waits or 3 with waits.
// - With wide and CP areas both on, basic fields do not steer them.
// - Basic wait mode 00 program, 01 off, 10 pin, 11 pin auto-wait.
// - Basic wait count codes 00 to 11 insert zero to three waits.
// - Program waits go only into data cycles of an access.
// - Reset sets widths and states to 1, mode to 00 and count to 11.
// - CP enable routes external accesses outside the enabled wide area to the CP area, else normal space.
`timescale 1ns/1ps
module ext_bus_wait_ctrl
	import ext_wait_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        acc_req,
	input  wire logic [1:0]  acc_region,
	output logic             acc_ready,
	output logic             acc_done,
	input  wire logic        ext_wait_n,
	output logic             ext_cs,
	output logic             ext_addr_phase,
	output logic             ext_data_phase,
	output logic             ext_wait_state,
	output logic             ext_bus_8bit,
	output logic             ext_cp_sel
);

	// ********************************************************
	// Configuration registers and wait pin
	// ********************************************************
	logic [7:0] wait_ctrl, area_ctrl, status;
	logic       wait_lvl, wait_req;

	apb_wait_regs u_regs (
		.clk       (clk),
		.rstn      (rstn),
		.ce        (ce),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.status_in (status),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.wait_ctrl (wait_ctrl),
		.area_ctrl (area_ctrl)
	);

	pin_sync3 u_wait_sync (
		.clk       (clk),
		.rstn      (rstn),
		.ce        (ce),
		.pin_in    (ext_wait_n),
		.level_out (wait_lvl)
	);

	assign wait_req = !wait_lvl;

	// ********************************************************
	// Effective settings for the access being started
	// ********************************************************
	logic       wide_en, cp_en, mux_en;
	logic       is_int, is_wide, is_cp;
	logic       set_8bit, set_t3, set_pin;
	logic [1:0] set_cnt, set_prog;
	wait_mode_t set_mode;

	assign wide_en = area_ctrl[WIDE_EN_BIT];
	assign cp_en   = area_ctrl[CP_EN_BIT];
	assign mux_en  = area_ctrl[MUX_EN_BIT];

	// Area decode and field selection; later areas override basic
	always_comb begin
		is_int   = (acc_region == RG_INT_MEM) || (acc_region == RG_INT_IO);
		is_wide  = (acc_region == RG_WIDE) && wide_en;
		is_cp    = !is_int && !is_wide && cp_en;
		set_8bit = wait_ctrl[BASIC_WIDTH_BIT];
		set_t3   = wait_ctrl[BASIC_STATE_BIT];
		set_mode = wait_mode_t'(wait_ctrl[WMODE_HI:WMODE_LO]);
		set_cnt  = wait_ctrl[WCOUNT_HI:WCOUNT_LO];
		if (is_wide) begin
			set_8bit = wait_ctrl[WIDE_WIDTH_BIT];
			set_t3   = wait_ctrl[WIDE_STATE_BIT];
			if (cp_en) begin
				set_mode = WIDE_WAIT_MODE;
				set_cnt  = WIDE_WAIT_COUNT;
			end
		end
		if (is_cp) begin
			set_8bit = CP_WIDTH_8;
			set_t3   = CP_THREE_STATE;
			set_mode = CP_WAIT_MODE;
			set_cnt  = CP_WAIT_COUNT;
		end
		// Two-state accesses never take waits
		if (!set_t3) begin
			set_mode = WM_DISABLED;
		end
		// Mode decode into program count and pin sampling
		unique case (set_mode)
			WM_PROGRAM: begin
				set_prog = set_cnt;
				set_pin  = 1'b0;
			end
			WM_DISABLED: begin
				set_prog = 2'h0;
				set_pin  = 1'b0;
			end
			WM_PIN: begin
				set_prog = set_cnt;
				set_pin  = 1'b1;
			end
			WM_PIN_AUTO: begin
				set_prog = 2'h0;
				set_pin  = 1'b1;
			end
		endcase
	end

	// ********************************************************
	// Access sequencer
	// ********************************************************
	seq_state_t state_q, state_d;
	logic [1:0] cnt_q, cnt_d, wcnt_q, wcnt_d;
	logic       t3_q, t3_d, pin_q, pin_d, int_q, int_d;
	logic       w8_q, w8_d, cp_q, cp_d;
	logic       start;

	assign start = (state_q == S_IDLE) && acc_req;

	// Next state; settings are latched so writes mid-access are safe
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		wcnt_d  = wcnt_q;
		t3_d    = t3_q;
		pin_d   = pin_q;
		int_d   = int_q;
		w8_d    = w8_q;
		cp_d    = cp_q;
		unique case (state_q)
			S_IDLE: begin
				if (acc_req) begin
					int_d  = is_int;
					t3_d   = set_t3;
					pin_d  = set_pin;
					wcnt_d = set_prog;
					// Internal cycles stay 16-bit, never routed out
					w8_d   = is_int ? 1'b0 : set_8bit;
					cp_d   = is_int ? 1'b0 : is_cp;
					cnt_d  = ADDR_PHASE_CYCLES - 2'h1;
					if (is_int) begin
						state_d = S_LAST;
					end else if (mux_en) begin
						state_d = S_ADDR;
					end else begin
						state_d = S_DATA;
					end
				end
			end
			S_ADDR: begin
				// Address phase length is fixed by ADDR_PHASE_CYCLES
				if (cnt_q == 2'h0) begin
					state_d = S_DATA;
				end else begin
					cnt_d = cnt_q - 2'h1;
				end
			end
			S_DATA: begin
				// T1 of a 2-state cycle, or T1 and T2 of a 3-state one
				if (!t3_q) begin
					state_d = S_LAST;
				end else if (cnt_q == 2'h0) begin
					if (wcnt_q != 2'h0 || (pin_q && wait_req)) begin
						state_d = S_WAIT;
					end else begin
						state_d = S_LAST;
					end
				end else begin
					cnt_d = cnt_q - 2'h1;
				end
			end
			S_WAIT: begin
				if (wcnt_q != 2'h0) begin
					wcnt_d = wcnt_q - 2'h1;
					if (wcnt_q == 2'h1 && !(pin_q && wait_req)) begin
						state_d = S_LAST;
					end
				end else if (!(pin_q && wait_req)) begin
					state_d = S_LAST;
				end
			end
			S_LAST: begin
				state_d = S_IDLE;
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
		// Data phase counter reload on entry from the address phase or from idle
		if (state_q != S_DATA && state_d == S_DATA) begin
			cnt_d = 2'h1;
		end
		if (state_q == S_IDLE && state_d == S_DATA) begin
			cnt_d = 2'h1;
		end
	end

	// Sequencer registers, frozen while the clock enable is low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= S_IDLE;
			cnt_q   <= 2'h0;
			wcnt_q  <= 2'h0;
			t3_q    <= 1'b0;
			pin_q   <= 1'b0;
			int_q   <= 1'b0;
			w8_q    <= 1'b0;
			cp_q    <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			wcnt_q  <= wcnt_d;
			t3_q    <= t3_d;
			pin_q   <= pin_d;
			int_q   <= int_d;
			w8_q    <= w8_d;
			cp_q    <= cp_d;
		end
	end

	// ********************************************************
	// Bus strobes and status
	// ********************************************************
	// Wait states count as data cycles; address phase never stretches
	assign acc_ready      = (state_q == S_IDLE);
	assign acc_done       = (state_q == S_LAST);
	assign ext_cs         = (state_q != S_IDLE) && !int_q;
	assign ext_addr_phase = (state_q == S_ADDR);
	assign ext_wait_state = (state_q == S_WAIT);
	assign ext_data_phase = ext_cs && !ext_addr_phase;
	assign ext_bus_8bit   = w8_q;
	assign ext_cp_sel     = cp_q;
	assign status = {1'b0, wait_req, cp_q, w8_q, t3_q, state_q};

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	internal_fixed_a: assert property (
		ce && start && is_int |=> state_q == S_LAST && !ext_cs && !w8_q)
		else $error("internal access not fixed single cycle");
	wide_width_a: assert property (
		ce && start && is_wide |=> w8_q == $past(wait_ctrl[WIDE_WIDTH_BIT]))
		else $error("wide area width not taken from its bit");
	two_state_a: assert property (
		ce && state_q == S_DATA && !t3_q |=> state_q == S_LAST)
		else $error("two-state access took extra cycles");
	mux_addr_a: assert property (
		ce && start && !is_int && mux_en |=> ext_addr_phase && !ext_wait_state)
		else $error("multiplexed access skipped address phase");
	basic_width_a: assert property (
		ce && start && acc_region == RG_BASIC && !cp_en
		|=> w8_q == $past(wait_ctrl[BASIC_WIDTH_BIT]) && t3_q ==
			$past(wait_ctrl[BASIC_STATE_BIT]))
		else $error("basic area width or states wrong");
	wide_ignore_a: assert property (
		ce && start && is_wide && cp_en && set_t3 |=> wcnt_q == WIDE_WAIT_COUNT)
		else $error("basic wait fields steered a wide access");
	prog_count_a: assert property (
		ce && start && acc_region == RG_BASIC && !cp_en &&
		wait_ctrl[BASIC_STATE_BIT] && wait_ctrl[WMODE_HI:WMODE_LO] == 2'b00
		|=> wcnt_q == $past(wait_ctrl[WCOUNT_HI:WCOUNT_LO]))
		else $error("program wait count not loaded");
	wait_in_data_a: assert property (
		ext_wait_state |-> ext_data_phase && t3_q)
		else $error("wait state outside a data cycle");
	reset_value_a: assert property (
		$rose(rstn) |-> wait_ctrl == WAIT_CTRL_RST)
		else $error("wait control reset value wrong");
	cp_route_a: assert property (
		ce && start && acc_region == RG_BASIC |=> ext_cp_sel == $past(cp_en))
		else $error("CP routing does not follow enable");
	pin_hold_a: assert property (
		ce && state_q == S_WAIT && wcnt_q == 2'h0 && pin_q && wait_req
		|=> state_q == S_WAIT)
		else $error("pin wait did not extend the cycle");

	mux_access_c: cover property (
		ce && start && mux_en && !is_int ##1 ext_addr_phase[*2] ##1
		ext_data_phase);
	pin_wait_c: cover property (
		state_q == S_WAIT && wcnt_q == 2'h0 && wait_req);
	three_wait_c: cover property (
		ext_wait_state[*3] ##1 acc_done);
endmodule

// *** tb/ext_wait_device.sv ***
// Model of an external device that stretches accesses with its wait pin
`timescale 1ns/1ps
module ext_wait_device (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       sel,
	input  wire logic [3:0] hold_len,
	output logic            wait_n
);
	logic [3:0] left_q;
	logic [3:0] left_d;
	logic       sel_q;
	logic       sel_d;

	// Arm on select only, so a phase change inside one access cannot rearm
	always_comb begin
		left_d = (left_q != 4'h0) ? left_q - 4'h1 : 4'h0;
		sel_d  = sel;
		if (sel && !sel_q) begin
			left_d = hold_len;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			left_q <= 4'h0;
			sel_q  <= 1'b0;
		end else begin
			left_q <= left_d;
			sel_q  <= sel_d;
		end
	end

	// Pin has a pull-up, so a released pin reads high
	assign wait_n = (left_q == 4'h0);
endmodule

// *** tb/external_area_bus_timing_config_test.sv ***
// Self-checking bench for the external area bus timing controller
`timescale 1ns/1ps
module external_area_bus_timing_config_test
	import ext_wait_pkg::*;
;
	logic        clk, rstn, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        acc_req, acc_ready, acc_done, ext_wait_n, ext_cs;
	logic        ext_addr_phase, ext_data_phase, ext_wait_state;
	logic        ext_bus_8bit, ext_cp_sel, err, w8, cp;
	logic [1:0]  acc_region;
	logic [3:0]  hold_len;
	int          miscompares, tests_run, ticks, cyc, wts, adr, wadr, cs, dat;

	ext_bus_wait_ctrl dut (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.acc_req(acc_req), .acc_region(acc_region), .acc_ready(acc_ready),
		.acc_done(acc_done), .ext_wait_n(ext_wait_n), .ext_cs(ext_cs),
		.ext_addr_phase(ext_addr_phase), .ext_data_phase(ext_data_phase),
		.ext_wait_state(ext_wait_state), .ext_bus_8bit(ext_bus_8bit),
		.ext_cp_sel(ext_cp_sel));

	ext_wait_device partner (.clk(clk), .rstn(rstn), .sel(ext_cs),
		.hold_len(hold_len), .wait_n(ext_wait_n));

	// ********************************************************
	// Clock, timeout and shared tasks
	// ********************************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Ceiling well above the few hundred cycles the run needs
	always @(posedge clk) begin
		ticks++;
		if (ticks == 5000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s seen %0h expected %0h", $time,
				msg, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// One access; counts cycles from the taking edge up to acc_done
	task automatic access(input logic [1:0] rg);
		@(posedge clk);
		acc_region <= rg;
		acc_req    <= 1'b1;
		@(posedge clk);
		while (acc_ready !== 1'b1) @(posedge clk);
		acc_req <= 1'b0;
		cyc = 0;
		wts = 0;
		adr = 0;
		wadr = 0;
		cs = 0;
		dat = 0;
		do begin
			@(posedge clk);
			cyc++;
			if (cyc == 1) begin
				w8 = ext_bus_8bit;
				cp = ext_cp_sel;
			end
			wts += int'(ext_wait_state);
			adr += int'(ext_addr_phase);
			wadr += int'(ext_wait_state & ext_addr_phase);
			cs += int'(ext_cs);
			dat += int'(ext_data_phase);
		end while (acc_done !== 1'b1);
	endtask

	// ********************************************************
	// Scenarios
	// ********************************************************
	task automatic test_reset();
		apb(1'b0, WAIT_CTRL_OFS, 8'h00);
		check(rd, 32'hf3, "wait ctrl reset");
		access(2'b10);
		check(cyc, 6, "reset access cycles");
		check(w8, 1'b1, "reset width");
		apb(1'b1, 8'h0c, 8'h55);
		check(err, 1'b1, "unmapped error");
	endtask

	task automatic test_internal();
		apb(1'b1, WAIT_CTRL_OFS, 8'h03);
		for (int r = 0; r < 2; r++) begin
			access(r[1:0]);
			check(cyc, 1, "internal cycles");
			check(cs + wts, 0, "internal no ext");
		end
	endtask

	task automatic test_basic();
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, WAIT_CTRL_OFS, {6'h34, c[1:0]});
			access(2'b10);
			check(cyc, 3 + c, "program wait cycles");
			check(wts, c, "program wait count");
			check(w8, 1'b0, "basic 16 bit");
		end
		apb(1'b1, WAIT_CTRL_OFS, 8'h23);
		access(2'b10);
		check(cyc, 2, "two state cycles");
		check(wts + 2 * w8, 2, "two state no wait, 8 bit");
		apb(1'b1, WAIT_CTRL_OFS, 8'h17);
		access(2'b10);
		check(cyc, 3, "waits disabled");
	endtask

	task automatic test_pin();
		apb(1'b1, WAIT_CTRL_OFS, 8'h19);
		access(2'b10);
		check(cyc, 4, "pin mode idle pin");
		// Synchroniser lag is long, so the address phase and three
		// program waits give the pin time to arrive before the end
		apb(1'b1, AREA_CTRL_OFS, 8'h04);
		apb(1'b1, WAIT_CTRL_OFS, 8'h1b);
		hold_len <= 4'h8;
		access(2'b10);
		check(cyc > 8, 1'b1, "pin mode stretched");
		hold_len <= 4'h0;
		apb(1'b1, AREA_CTRL_OFS, 8'h00);
		apb(1'b1, WAIT_CTRL_OFS, 8'h1e);
		access(2'b10);
		check(cyc, 3, "auto mode idle pin");
	endtask

	task automatic test_wide();
		apb(1'b1, AREA_CTRL_OFS, 8'h01);
		apb(1'b1, WAIT_CTRL_OFS, 8'h32);
		access(2'b11);
		check(cyc + 4 * w8, 2, "wide 2 state 16 bit");
		apb(1'b1, WAIT_CTRL_OFS, 8'hc2);
		access(2'b11);
		check(cyc + 8 * w8, 13, "wide 3 state 8 bit");
	endtask

	task automatic test_mux();
		apb(1'b1, AREA_CTRL_OFS, 8'h04);
		apb(1'b1, WAIT_CTRL_OFS, 8'h12);
		access(2'b10);
		check(cyc, 7, "mux 3 state cycles");
		check(adr, 2, "mux address cycles");
		check(dat, 5, "mux data cycles");
		check(wts + 4 * wadr, 2, "waits in data only");
		apb(1'b1, WAIT_CTRL_OFS, 8'h02);
		access(2'b10);
		check(cyc, 4, "mux 2 state cycles");
	endtask

	task automatic test_cp();
		apb(1'b1, AREA_CTRL_OFS, 8'h03);
		apb(1'b1, WAIT_CTRL_OFS, 8'h44);
		access(2'b11);
		check(cyc + 8 * w8, 6, "basic fields ignored");
		access(2'b10);
		check({cp, w8}, 2'b11, "cp routing");
		check(cyc, 6, "cp fixed timing");
		apb(1'b1, AREA_CTRL_OFS, 8'h01);
		access(2'b10);
		check(cp, 1'b0, "normal space routing");
	endtask

	// Clock enable low: a pending request must not start
	task automatic test_freeze();
		@(posedge clk);
		ce         <= 1'b0;
		acc_region <= 2'b10;
		acc_req    <= 1'b1;
		repeat (3) @(posedge clk);
		check(acc_ready, 1'b1, "frozen request not taken");
		check(ext_cs, 1'b0, "frozen bus stays idle");
		check(pready, 1'b0, "no bus answer while frozen");
		ce      <= 1'b1;
		acc_req <= 1'b0;
		@(posedge clk);
	endtask

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		acc_req = 1'b0;
		acc_region = 2'b00;
		hold_len = 4'h0;
		miscompares = 0;
		tests_run = 0;
		ticks = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		test_reset();
		test_internal();
		test_basic();
		test_pin();
		test_wide();
		test_mux();
		test_cp();
		test_freeze();
		give_verdict();
	end
endmodule
